// file: rtl/io_space_pkg.sv
// Purpose: Shared constants and carriers for the I/O space decoder
// Assumes: 8-bit registers, byte addressed data space
// Notes:   Offsets are I/O addresses; data-space alias adds the fixed offset
package io_space_pkg;

  localparam int          DATA_W          = 8;
  localparam int          IO_AW           = 6;
  localparam int          DS_AW           = 9;

  // Address windows
  localparam logic [5:0]  BIT_RANGE_LAST  = 6'h1f;
  localparam logic [8:0]  DS_IO_OFFSET    = 9'h020;
  localparam logic [8:0]  DS_IO_LAST      = 9'h05f;
  localparam logic [8:0]  DS_EXT_FIRST    = 9'h060;
  localparam logic [8:0]  DS_EXT_LAST     = 9'h1ff;

  // Register offsets in I/O space
  localparam logic [5:0]  PORT_B_INPUT_PINS        = 6'h03;
  localparam logic [5:0]  PORT_B_DIRECTION         = 6'h04;
  localparam logic [5:0]  PORT_B_OUTPUT            = 6'h05;
  localparam logic [5:0]  PORT_C_INPUT_PINS        = 6'h06;
  localparam logic [5:0]  PORT_C_DIRECTION         = 6'h07;
  localparam logic [5:0]  PORT_C_OUTPUT            = 6'h08;
  localparam logic [5:0]  PORT_D_INPUT_PINS        = 6'h09;
  localparam logic [5:0]  PORT_D_DIRECTION         = 6'h0a;
  localparam logic [5:0]  PORT_D_OUTPUT            = 6'h0b;
  localparam logic [5:0]  TIMER8_FLAGS             = 6'h15;
  localparam logic [5:0]  TIMER16_FLAGS            = 6'h16;
  localparam logic [5:0]  GENERAL_PURPOSE_ZERO     = 6'h1e;
  localparam logic [5:0]  NVM_CONTROL              = 6'h1f;
  localparam logic [5:0]  NVM_DATA                 = 6'h20;
  localparam logic [5:0]  NVM_ADDRESS_LOW          = 6'h21;
  localparam logic [5:0]  NVM_ADDRESS_HIGH         = 6'h22;
  localparam logic [5:0]  TIMER_GLOBAL_CONTROL     = 6'h23;
  localparam logic [5:0]  TIMER8_CONTROL_A         = 6'h24;
  localparam logic [5:0]  TIMER8_CONTROL_B         = 6'h25;
  localparam logic [5:0]  TIMER8_COUNT             = 6'h26;
  localparam logic [5:0]  TIMER8_COMPARE_A         = 6'h27;
  localparam logic [5:0]  TIMER8_COMPARE_B         = 6'h28;
  localparam logic [5:0]  PLL_CONTROL_STATUS       = 6'h29;
  localparam logic [5:0]  GENERAL_PURPOSE_ONE      = 6'h2a;
  localparam logic [5:0]  GENERAL_PURPOSE_TWO      = 6'h2b;
  localparam logic [5:0]  SERIAL_PERIPH_CONTROL    = 6'h2c;
  localparam logic [5:0]  SERIAL_PERIPH_STATUS     = 6'h2d;
  localparam logic [5:0]  SERIAL_PERIPH_DATA       = 6'h2e;
  localparam logic [5:0]  COMPARATOR_CONTROL_STATUS = 6'h30;

  // Flag layouts (write one to clear)
  localparam logic [7:0]  TIMER8_FLAG_MASK  = 8'h07;
  localparam logic [7:0]  TIMER16_FLAG_MASK = 8'h2f;
  localparam logic [7:0]  REG_RESET         = 8'h00;

  // Core operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_IO_IN,
    OP_IO_OUT,
    SET_SINGLE_BIT_OP,
    CLEAR_SINGLE_BIT_OP,
    SKIP_IF_IO_BIT_SET_OP,
    SKIP_IF_IO_BIT_CLEAR_OP,
    DATA_SPACE_LOAD_OP
  } core_op_e;

  typedef struct packed {
    core_op_e    op;
    logic        store;
    logic [8:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } core_req_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic        skip;
    logic [7:0]  rdata;
  } core_rsp_s;

endpackage

// file: rtl/io_space_address_decoder.sv
// Purpose: Decode the core's I/O and data-space accesses onto the low register file
// Assumes: One request per cycle, answered on the next edge
// Notes:   Peripherals sit outside; they raise flag events and read registers
//
// Overview of operation
// - Bit set/clear only at addresses 0x00-0x1F
// - Bit test with skip in low range
// - Some status flags clear on written one
// - Bit set/clear is whole-register read-modify-write
// - I/O transfers reach only 64 locations
// - Data-space alias is I/O address plus 0x20
// - Extended range 0x60-0x1FF by load/store only
`timescale 1ns/100ps
module io_space_address_decoder #(
  parameter int NUM_LOCS = 64
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Core request and answer
  input  wire io_space_pkg::core_req_s  req,
  output io_space_pkg::core_rsp_s       rsp,
  // Extended space pass-through
  output logic                          ext_sel,
  output logic                          ext_we,
  output logic [8:0]                    ext_addr,
  output logic [7:0]                    ext_wdata,
  input  wire logic [7:0]               ext_rdata,
  // Port pins
  input  wire logic [7:0]               pin_b,
  input  wire logic [7:0]               pin_c,
  input  wire logic [7:0]               pin_d,
  // Flag events from timers
  input  wire logic [7:0]               timer8_events,
  input  wire logic [7:0]               timer16_events,
  // Register contents to peripherals
  output logic [NUM_LOCS*8-1:0]         reg_image
);

  initial
  begin
    if (NUM_LOCS != 64)
      $error("I/O space must be 64 locations");
  end

  logic [7:0] regs_q [NUM_LOCS];
  logic [7:0] pin_b_m_q, pin_b_s_q, pin_c_m_q, pin_c_s_q, pin_d_m_q, pin_d_s_q;
  io_space_pkg::core_rsp_s rsp_q, rsp_d;

  // Request classification
  wire logic        is_io_op   = req.op inside {io_space_pkg::OP_IO_IN,
                                                io_space_pkg::OP_IO_OUT};
  wire logic        is_bit_op  = req.op inside {io_space_pkg::SET_SINGLE_BIT_OP,
                                                io_space_pkg::CLEAR_SINGLE_BIT_OP};
  wire logic        is_test_op = req.op inside {io_space_pkg::SKIP_IF_IO_BIT_SET_OP,
                                                io_space_pkg::SKIP_IF_IO_BIT_CLEAR_OP};
  wire logic        is_ds_op   = (req.op == io_space_pkg::DATA_SPACE_LOAD_OP);
  wire logic        ds_in_io   = req.addr >= io_space_pkg::DS_IO_OFFSET &&
                                 req.addr <= io_space_pkg::DS_IO_LAST;
  wire logic        ds_in_ext  = req.addr >= io_space_pkg::DS_EXT_FIRST;
  wire logic [8:0]  ds_io_full = req.addr - io_space_pkg::DS_IO_OFFSET;
  // Only the low six address bits exist for I/O transfers
  wire logic [5:0]  io_addr    = is_ds_op ? ds_io_full[5:0] : req.addr[5:0];
  wire logic        low_range  = req.addr[8:5] == 4'h0;
  wire logic        io_hit     = (is_io_op && req.addr[8:6] == 3'h0)
                               || (is_ds_op && ds_in_io)
                               || ((is_bit_op || is_test_op) && low_range);
  wire logic        bad_req    = (req.op != io_space_pkg::OP_NONE) && !io_hit
                               && !(is_ds_op && ds_in_ext);

  // Implemented locations; everything else is reserved
  logic [NUM_LOCS-1:0] impl;
  logic [NUM_LOCS-1:0] ro_mask;
  always_comb
  begin
    impl = '0;
    ro_mask = '0;
    impl[io_space_pkg::PORT_B_INPUT_PINS] = 1'b1;
    impl[io_space_pkg::PORT_B_DIRECTION] = 1'b1;
    impl[io_space_pkg::PORT_B_OUTPUT] = 1'b1;
    impl[io_space_pkg::PORT_C_INPUT_PINS] = 1'b1;
    impl[io_space_pkg::PORT_C_DIRECTION] = 1'b1;
    impl[io_space_pkg::PORT_C_OUTPUT] = 1'b1;
    impl[io_space_pkg::PORT_D_INPUT_PINS] = 1'b1;
    impl[io_space_pkg::PORT_D_DIRECTION] = 1'b1;
    impl[io_space_pkg::PORT_D_OUTPUT] = 1'b1;
    impl[io_space_pkg::TIMER8_FLAGS] = 1'b1;
    impl[io_space_pkg::TIMER16_FLAGS] = 1'b1;
    impl[io_space_pkg::GENERAL_PURPOSE_ZERO] = 1'b1;
    impl[io_space_pkg::NVM_CONTROL] = 1'b1;
    impl[io_space_pkg::NVM_DATA] = 1'b1;
    impl[io_space_pkg::NVM_ADDRESS_LOW] = 1'b1;
    impl[io_space_pkg::NVM_ADDRESS_HIGH] = 1'b1;
    impl[io_space_pkg::TIMER_GLOBAL_CONTROL] = 1'b1;
    impl[io_space_pkg::TIMER8_CONTROL_A] = 1'b1;
    impl[io_space_pkg::TIMER8_CONTROL_B] = 1'b1;
    impl[io_space_pkg::TIMER8_COUNT] = 1'b1;
    impl[io_space_pkg::TIMER8_COMPARE_A] = 1'b1;
    impl[io_space_pkg::TIMER8_COMPARE_B] = 1'b1;
    impl[io_space_pkg::PLL_CONTROL_STATUS] = 1'b1;
    impl[io_space_pkg::GENERAL_PURPOSE_ONE] = 1'b1;
    impl[io_space_pkg::GENERAL_PURPOSE_TWO] = 1'b1;
    impl[io_space_pkg::SERIAL_PERIPH_CONTROL] = 1'b1;
    impl[io_space_pkg::SERIAL_PERIPH_STATUS] = 1'b1;
    impl[io_space_pkg::SERIAL_PERIPH_DATA] = 1'b1;
    impl[io_space_pkg::COMPARATOR_CONTROL_STATUS] = 1'b1;
    ro_mask[io_space_pkg::PORT_B_INPUT_PINS] = 1'b1;
    ro_mask[io_space_pkg::PORT_C_INPUT_PINS] = 1'b1;
    ro_mask[io_space_pkg::PORT_D_INPUT_PINS] = 1'b1;
  end

  // Flag bit masks per location
  function automatic logic [7:0] w1c_of(input logic [5:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a == io_space_pkg::TIMER8_FLAGS)
      m = io_space_pkg::TIMER8_FLAG_MASK;
    else if (a == io_space_pkg::TIMER16_FLAGS)
      m = io_space_pkg::TIMER16_FLAG_MASK;
    return m;
  endfunction

  // Current read value, pins sampled through two flops
  logic [7:0] cur_val;
  always_comb
  begin
    cur_val = 8'h00;
    if (impl[io_addr])
      cur_val = regs_q[io_addr];
    if (io_addr == io_space_pkg::PORT_B_INPUT_PINS)
      cur_val = pin_b_s_q;
    else if (io_addr == io_space_pkg::PORT_C_INPUT_PINS)
      cur_val = pin_c_s_q;
    else if (io_addr == io_space_pkg::PORT_D_INPUT_PINS)
      cur_val = pin_d_s_q;
  end

  // Write value: bit ops rebuild from the read value, so set flags go back as one, except the bit a clear op names
  wire logic [7:0] bit_mask  = 8'h01 << req.bit_sel;
  wire logic [7:0] rmw_val   = (req.op == io_space_pkg::SET_SINGLE_BIT_OP)
                             ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
  wire logic       wr_io     = io_hit && (req.op == io_space_pkg::OP_IO_OUT
                                          || is_bit_op
                                          || (is_ds_op && req.store));
  wire logic [7:0] wr_val    = is_bit_op ? rmw_val : req.wdata;
  // Reserved and read-only locations swallow writes
  wire logic       wr_ok     = wr_io && impl[io_addr] && !ro_mask[io_addr];
  wire logic [7:0] flag_m    = w1c_of(io_addr);

  // Register file; one generate lane per location
  for (genvar g = 0; g < NUM_LOCS; g++)
  begin : g_loc
    wire logic [7:0] evt = (g == int'(io_space_pkg::TIMER8_FLAGS))  ? timer8_events  & io_space_pkg::TIMER8_FLAG_MASK :
                           (g == int'(io_space_pkg::TIMER16_FLAGS)) ? timer16_events & io_space_pkg::TIMER16_FLAG_MASK :
                           8'h00;
    wire logic [7:0] fm  = w1c_of(6'(g));
    wire logic       hit = wr_ok && (io_addr == 6'(g));
    logic [7:0] nxt;
    always_comb
    begin
      nxt = regs_q[g];
      if (hit)
        nxt = (nxt & fm & ~wr_val) | (wr_val & ~fm);
      nxt = nxt | evt; // New event beats a clear in the same cycle
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        regs_q[g] <= io_space_pkg::REG_RESET;
      else
        regs_q[g] <= nxt;
    end
    assign reg_image[g*8 +: 8] = regs_q[g];
  end

  // Answer
  always_comb
  begin
    rsp_d = '0;
    rsp_d.valid = req.op != io_space_pkg::OP_NONE;
    rsp_d.error = bad_req;
    if (io_hit && !wr_io)
      rsp_d.rdata = cur_val;
    else if (is_ds_op && ds_in_ext && !req.store)
      rsp_d.rdata = ext_rdata;
    if (is_test_op && low_range)
      rsp_d.skip = (req.op == io_space_pkg::SKIP_IF_IO_BIT_SET_OP)
                 ? cur_val[req.bit_sel] : !cur_val[req.bit_sel];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_q <= '0;
      pin_b_m_q <= 8'h00;
      pin_b_s_q <= 8'h00;
      pin_c_m_q <= 8'h00;
      pin_c_s_q <= 8'h00;
      pin_d_m_q <= 8'h00;
      pin_d_s_q <= 8'h00;
    end
    else
    begin
      rsp_q <= rsp_d;
      pin_b_m_q <= pin_b;
      pin_b_s_q <= pin_b_m_q;
      pin_c_m_q <= pin_c;
      pin_c_s_q <= pin_c_m_q;
      pin_d_m_q <= pin_d;
      pin_d_s_q <= pin_d_m_q;
    end
  end

  assign rsp       = rsp_q;
  // Extended range never reached by I/O transfers
  assign ext_sel   = is_ds_op && ds_in_ext;
  assign ext_we    = ext_sel && req.store;
  assign ext_addr  = req.addr;
  assign ext_wdata = req.wdata;

endmodule

// file: testbench/io_space_sva.sv
// Purpose: Port assertions for the I/O space decoder
// Assumes: One clock, async active-high reset
// Notes:   Pins and reserved bits are not judged here
`timescale 1ns/100ps
module io_space_sva #(
  parameter int NUM_LOCS = 64
) (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst,
  // Core side
  input wire io_space_pkg::core_req_s req,
  input wire io_space_pkg::core_rsp_s rsp,
  input wire logic                    ext_sel,
  // Flag events and register image
  input wire logic [7:0]              timer8_events,
  input wire logic [7:0]              timer16_events,
  input wire logic [NUM_LOCS*8-1:0]   reg_image
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wire [8:0] a       = req.addr;
  wire       is_bit  = req.op inside {io_space_pkg::SET_SINGLE_BIT_OP,
                                      io_space_pkg::CLEAR_SINGLE_BIT_OP};
  wire       is_test = req.op inside {io_space_pkg::SKIP_IF_IO_BIT_SET_OP,
                                      io_space_pkg::SKIP_IF_IO_BIT_CLEAR_OP};
  wire       is_tset = req.op == io_space_pkg::SKIP_IF_IO_BIT_SET_OP;
  wire       is_io   = req.op inside {io_space_pkg::OP_IO_IN, io_space_pkg::OP_IO_OUT};
  wire       is_out  = req.op == io_space_pkg::OP_IO_OUT;
  wire       is_ds   = req.op == io_space_pkg::DATA_SPACE_LOAD_OP;
  wire       cur_bit = reg_image[{a[5:0], req.bit_sel}];
  wire       quiet   = timer8_events == 8'h00 && timer16_events == 8'h00;
  wire [7:0] gp0     = reg_image[9'h0f0 +: 8];
  wire [7:0] tf0     = reg_image[9'h0a8 +: 8];
  wire [7:0] tf1     = reg_image[9'h0b0 +: 8];
  wire [7:0] gp1     = reg_image[9'h150 +: 8];
  wire [7:0] rsv     = reg_image[9'h010 +: 8];

  sequence bit_high_s;
    is_bit && a > 9'h01f;
  endsequence
  sequence alias_store_s;
    is_ds && req.store && a == 9'h04a;
  endsequence

  bit_refuse_a: assert property (bit_high_s |=> rsp.valid && rsp.error)
    else $error("bit op above low range not refused");
  skip_value_a: assert property (is_test && a <= 9'h01f |=>
    rsp.valid && rsp.skip == ($past(cur_bit) == $past(is_tset)))
    else $error("skip does not follow tested bit");
  flag_clear_a: assert property (is_out && a == 9'h015 && quiet |=>
    (tf0 & $past(req.wdata)) == 8'h00)
    else $error("written one did not clear flag");
  rmw_clear_a: assert property (is_bit && a == 9'h016 && quiet |=>
    (tf1 & io_space_pkg::TIMER16_FLAG_MASK) == 8'h00)
    else $error("bit op left a set flag standing");
  io_reach_a: assert property (is_io && a > 9'h03f |=> rsp.valid && rsp.error)
    else $error("transfer beyond 64 locations not refused");
  alias_store_a: assert property (alias_store_s |=> gp1 == $past(req.wdata))
    else $error("aliased store missed its register");
  ext_only_a: assert property (ext_sel == (is_ds && a >= 9'h060))
    else $error("extended select wrong");
  reserved_keep_a: assert property (is_out && a == 9'h002 |=>
    rsv == 8'h00 && $stable(gp0))
    else $error("reserved write changed state");
endmodule

bind io_space_address_decoder io_space_sva #(.NUM_LOCS(NUM_LOCS)) sva (.sys_clk, .rst, .req,
  .rsp, .ext_sel, .timer8_events, .timer16_events, .reg_image);

// file: testbench/ext_space_model.sv
// Purpose: Extended data space memory behind the decoder
// Assumes: Same-cycle read, write at the clock edge
// Notes:   Unselected reads give a moving pattern, never the last value
`timescale 1ns/100ps
module ext_space_model (
  // Clock
  input  wire logic       sys_clk,
  // Extended access
  input  wire logic       ext_sel,
  input  wire logic       ext_we,
  input  wire logic [8:0] ext_addr,
  input  wire logic [7:0] ext_wdata,
  output logic [7:0]      ext_rdata
);
  logic [7:0] mem [512];
  logic [7:0] junk_q = 8'h5a;
  always @(posedge sys_clk)
  begin
    junk_q <= ~junk_q;
    if (ext_sel && ext_we)
      mem[ext_addr] <= ext_wdata;
  end
  assign ext_rdata = ext_sel ? mem[ext_addr] : junk_q;
endmodule

// file: testbench/io_space_address_decoder_test.sv
// Purpose: Directed test of the I/O space decoder
// Assumes: One request in flight, answer one edge later
// Notes:   Pins held steady so sync delay never matters
`timescale 1ns/100ps
module io_space_address_decoder_test;
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  io_space_pkg::core_req_s req = '0;
  io_space_pkg::core_rsp_s rsp;
  logic                    ext_sel;
  logic                    ext_we;
  logic [8:0]              ext_addr;
  logic [7:0]              ext_wdata;
  logic [7:0]              ext_rdata;
  logic [7:0]              pin_b = 8'h3c;
  logic [7:0]              pin_c = 8'h81;
  logic [7:0]              pin_d = 8'h18;
  logic [7:0]              timer8_events = 8'h00;
  logic [7:0]              timer16_events = 8'h00;
  logic [511:0]            reg_image;
  int                      errors = 0;
  int                      num_checks = 0;
  int                      cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  io_space_address_decoder dut (.sys_clk, .rst, .req, .rsp, .ext_sel, .ext_we, .ext_addr,
    .ext_wdata, .ext_rdata, .pin_b, .pin_c, .pin_d, .timer8_events, .timer16_events, .reg_image);
  ext_space_model far (.sys_clk, .ext_sel, .ext_we, .ext_addr, .ext_wdata, .ext_rdata);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    check8(what, {7'h00, exp}, {7'h00, got});
  endtask

  // Idle edge between requests keeps each answer alone in its cycle
  // Only the reserved check in test_rw writes a reserved location, and it is not refused
  task automatic access(input io_space_pkg::core_op_e op, input logic st, input logic [8:0] a,
                        input logic [2:0] b, input logic [7:0] wd);
    @(posedge sys_clk);
    req <= '{op, st, a, b, wd};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
    access(io_space_pkg::OP_IO_IN, 1'b0, a, 3'h0, 8'h00);
    check8(what, exp, rsp.rdata);
  endtask

  task automatic test_rw();
    rd(9'h01e, 8'h00, "gp0 reset");
    access(io_space_pkg::OP_IO_OUT, 1'b0, 9'h01e, 3'h0, 8'ha5);
    rd(9'h01e, 8'ha5, "gp0 write");
    rd(9'h003, 8'h3c, "pins b");
    access(io_space_pkg::OP_IO_OUT, 1'b0, 9'h003, 3'h0, 8'hff);
    rd(9'h003, 8'h3c, "pins b read only");
    access(io_space_pkg::OP_IO_OUT, 1'b0, 9'h002, 3'h0, 8'h77);
    rd(9'h002, 8'h00, "reserved");
    access(io_space_pkg::OP_IO_IN, 1'b0, 9'h040, 3'h0, 8'h00);
    check1("in beyond reach", 1'b1, rsp.error);
    $display("test_rw done");
  endtask

  task automatic test_bits();
    access(io_space_pkg::SET_SINGLE_BIT_OP, 1'b0, 9'h005, 3'h2, 8'h00);
    access(io_space_pkg::SET_SINGLE_BIT_OP, 1'b0, 9'h005, 3'h7, 8'h00);
    rd(9'h005, 8'h84, "set bits");
    access(io_space_pkg::CLEAR_SINGLE_BIT_OP, 1'b0, 9'h005, 3'h2, 8'h00);
    rd(9'h005, 8'h80, "clear bit");
    access(io_space_pkg::SET_SINGLE_BIT_OP, 1'b0, 9'h020, 3'h0, 8'h00);
    check1("set above range", 1'b1, rsp.error);
    rd(9'h020, 8'h00, "no effect above range");
    access(io_space_pkg::SKIP_IF_IO_BIT_SET_OP, 1'b0, 9'h01e, 3'h0, 8'h00);
    check1("skip on set", 1'b1, rsp.skip);
    access(io_space_pkg::SKIP_IF_IO_BIT_SET_OP, 1'b0, 9'h01e, 3'h1, 8'h00);
    check1("no skip on set", 1'b0, rsp.skip);
    access(io_space_pkg::SKIP_IF_IO_BIT_CLEAR_OP, 1'b0, 9'h01e, 3'h1, 8'h00);
    check1("skip on clear", 1'b1, rsp.skip);
    $display("test_bits done");
  endtask

  task automatic test_flags();
    @(posedge sys_clk);
    timer8_events <= 8'h07;
    timer16_events <= 8'h2f;
    @(posedge sys_clk);
    timer8_events <= 8'h00;
    timer16_events <= 8'h00;
    rd(9'h015, 8'h07, "timer8 flags up");
    access(io_space_pkg::OP_IO_OUT, 1'b0, 9'h015, 3'h0, 8'h01);
    rd(9'h015, 8'h06, "one clears flag");
    // Set a flag bit, not a spare one, so no written one lingers
    access(io_space_pkg::SET_SINGLE_BIT_OP, 1'b0, 9'h016, 3'h5, 8'h00);
    rd(9'h016, 8'h00, "bit set clears flags");
    $display("test_flags done");
  endtask

  task automatic test_ranges();
    access(io_space_pkg::DATA_SPACE_LOAD_OP, 1'b1, 9'h04a, 3'h0, 8'h5a);
    rd(9'h02a, 8'h5a, "aliased store");
    access(io_space_pkg::DATA_SPACE_LOAD_OP, 1'b0, 9'h03e, 3'h0, 8'h00);
    check8("aliased load", 8'ha5, rsp.rdata);
    access(io_space_pkg::DATA_SPACE_LOAD_OP, 1'b1, 9'h1ff, 3'h0, 8'hc3);
    access(io_space_pkg::DATA_SPACE_LOAD_OP, 1'b0, 9'h1ff, 3'h0, 8'h00);
    check8("extended load", 8'hc3, rsp.rdata);
    access(io_space_pkg::OP_IO_IN, 1'b0, 9'h060, 3'h0, 8'h00);
    check1("in on extended", 1'b1, rsp.error);
    $display("test_ranges done");
  endtask

  // Whole run is near 80 cycles; the ceiling only cuts a hang
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    test_rw();
    test_bits();
    test_flags();
    test_ranges();
    complete_run();
  end
endmodule
